// [design/pmc_pkg.sv]
// Constants, types and register map of the power mode controller
//
// Summary of operation
// - Reset and power-up start in full-on
// - Active: PLL on but bypassed, clocks run
// - New multiplier applied only on full-on entry
// - PLL may be disabled while in active
// - DMA to L1 allowed in active, not sleep
// - Sleep: core clock stops, PLL and system run
// - Sleep wakeup picks mode from bypass bit
// - Deep sleep: PLL and clocks off, async blocked
// - Deep sleep exits only on reset, RTC or CAN
// - RTC interrupt in deep sleep gives active
// - Reset in deep sleep gives full-on
// - CAN wakeup leaves sleep, deep sleep, regulator off
// - Rate field 00 in full-on or active enters hibernate, core unpowered
// - Hibernate ends on RTC, CAN, reset, external
package pmc_pkg;

   // ****************************************************
   // Register map and fields
   // ****************************************************
   localparam logic [3:0] PLL_CONTROL_REG_OFF  = 4'h0;
   localparam logic [3:0] REG_CTL_OFF  = 4'h4;
   localparam logic [3:0] MODE_REQ_OFF = 4'h8;
   localparam logic [3:0] STATUS_OFF   = 4'hC;
   localparam int         PLL_DIS_BIT  = 0;
   localparam int         BYPASS_BIT   = 1;
   localparam int         MULT_LSB     = 4;
   localparam logic [5:0] MULT_RST     = 6'h0A;
   localparam logic [1:0] RATE_RST     = 2'h3;
   localparam logic [1:0] RATE_OFF     = 2'h0;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // Mode request commands
   localparam logic [2:0] CMD_FULL  = 3'h1;
   localparam logic [2:0] CMD_ACT   = 3'h2;
   localparam logic [2:0] CMD_SLEEP = 3'h3;
   localparam logic [2:0] CMD_DEEP  = 3'h4;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int         CLK_NS     = 8;
   localparam int         SETTLE_NS  = 80;
   localparam int         SETTLE_INT = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] SETTLE_CYC = 4'(SETTLE_INT);

   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [5:0] {
      ST_FULL  = 6'h01,
      ST_ACT   = 6'h02,
      ST_SLEEP = 6'h04,
      ST_DEEP  = 6'h08,
      ST_HIB   = 6'h10,
      ST_SET   = 6'h20
   } pmc_state_t;

   typedef struct packed {
      logic pll_en;
      logic pll_bypass;
      logic core_clk_en;
      logic sys_clk_en;
      logic core_power;
      logic dma_l1_ok;
      logic async_block;
   } pmc_pwr_t;

endpackage

// [design/pmc_top.sv]
// Power mode controller with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module pmc_top (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [3:0]    s_awaddr,
   input  wire logic          s_awvalid,
   output var  logic          s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output var  logic          s_wready,
   output var  logic [1:0]    s_bresp,
   output var  logic          s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [3:0]    s_araddr,
   input  wire logic          s_arvalid,
   output var  logic          s_arready,
   output var  logic [31:0]   s_rdata,
   output var  logic [1:0]    s_rresp,
   output var  logic          s_rvalid,
   input  wire logic          s_rready,
   input  wire logic          wake_event,
   input  wire logic          rtc_irq,
   input  wire logic          can_wake,
   input  wire logic          ext_wake,
   input  wire logic          reset_wake,
   output var  pmc_pkg::pmc_pwr_t pwr,
   output var  logic [5:0]    core_mult
);

   // ****************************************************
   // Declarations
   // ****************************************************
   pmc_pkg::pmc_state_t state_q;
   pmc_pkg::pmc_state_t tgt_q;
   pmc_pkg::pmc_state_t tgt_d;
   logic                go_d;
   logic [3:0]          cnt_q;
   logic                pll_dis_q;
   logic                bypass_q;
   logic [5:0]          mult_pend_q;
   logic [1:0]          rate_q;
   logic                aw_have_q;
   logic                w_have_q;
   logic [3:0]          waddr_q;
   logic [31:0]         wdata_q;
   logic                wr_fire;
   logic                hib_wr;
   logic                mode_wr;
   logic [2:0]          cmd;

   // Table of what each mode does to the PLL and clocks
   function automatic pmc_pkg::pmc_pwr_t settings(
      input pmc_pkg::pmc_state_t m,
      input logic                dis);
      pmc_pkg::pmc_pwr_t p;
      p = '0;
      case (m)
         pmc_pkg::ST_FULL: begin
            p = 7'b1011110;
         end
         pmc_pkg::ST_ACT: begin
            p = 7'b1111110;
            p.pll_en = !dis;
         end
         pmc_pkg::ST_SLEEP: begin
            p = 7'b1001100;
         end
         pmc_pkg::ST_DEEP: begin
            p = 7'b0000101;
         end
         default: begin
            p = 7'b0000001;
         end
      endcase
      return p;
   endfunction

   // Maps a mode command to its state, full-on if unknown
   function automatic pmc_pkg::pmc_state_t cmd_state(
      input logic [2:0] c);
      if (c == pmc_pkg::CMD_ACT) begin
         return pmc_pkg::ST_ACT;
      end else if (c == pmc_pkg::CMD_SLEEP) begin
         return pmc_pkg::ST_SLEEP;
      end else if (c == pmc_pkg::CMD_DEEP) begin
         return pmc_pkg::ST_DEEP;
      end else begin
         return pmc_pkg::ST_FULL;
      end
   endfunction

   // ****************************************************
   // AXI4-Lite write channel
   // ****************************************************
   assign wr_fire = aw_have_q && w_have_q && !s_bvalid;
   assign hib_wr  = wr_fire && waddr_q == pmc_pkg::REG_CTL_OFF
                    && wdata_q[1:0] == pmc_pkg::RATE_OFF;
   assign mode_wr = wr_fire && waddr_q == pmc_pkg::MODE_REQ_OFF;
   assign cmd     = wdata_q[2:0];

   // Address and data are caught in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         waddr_q   <= 4'h0;
         wdata_q   <= 32'h0;
         s_awready <= 1'b1;
         s_wready  <= 1'b1;
         s_bvalid  <= 1'b0;
         s_bresp   <= pmc_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_have_q <= 1'b1;
            waddr_q   <= {s_awaddr[3:2], 2'b00};
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_wdata;
            s_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_bvalid  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_bresp   <= (s_wstrb == 4'h0) ? pmc_pkg::RESP_OKAY
                                           : pmc_pkg::RESP_OKAY;
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
      end
   end

   // Control fields; the status word is read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_dis_q   <= 1'b0;
         bypass_q    <= 1'b0;
         mult_pend_q <= pmc_pkg::MULT_RST;
         rate_q      <= pmc_pkg::RATE_RST;
      end else begin
         if (wr_fire && waddr_q == pmc_pkg::PLL_CONTROL_REG_OFF) begin
            bypass_q    <= wdata_q[pmc_pkg::BYPASS_BIT];
            mult_pend_q <= wdata_q[pmc_pkg::MULT_LSB +: 6];
            // Disabling the PLL is only legal in active
            if (state_q == pmc_pkg::ST_ACT) begin
               pll_dis_q <= wdata_q[pmc_pkg::PLL_DIS_BIT];
            end else begin
               pll_dis_q <= 1'b0;
            end
         end
         if (go_d && tgt_d == pmc_pkg::ST_HIB) begin
            rate_q <= pmc_pkg::RATE_OFF;
         end else if (state_q == pmc_pkg::ST_HIB && go_d) begin
            rate_q <= pmc_pkg::RATE_RST;
         end else if (wr_fire && !hib_wr
                      && waddr_q == pmc_pkg::REG_CTL_OFF) begin
            rate_q <= wdata_q[1:0];
         end
      end
   end

   // ****************************************************
   // AXI4-Lite read channel
   // ****************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0;
         s_rresp   <= pmc_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rresp   <= pmc_pkg::RESP_OKAY;
         s_rdata   <= 32'h0;
         if (s_araddr[3:2] == pmc_pkg::PLL_CONTROL_REG_OFF[3:2]) begin
            s_rdata <= {22'h0, mult_pend_q, 2'h0, bypass_q, pll_dis_q};
         end else if (s_araddr[3:2] == pmc_pkg::REG_CTL_OFF[3:2]) begin
            s_rdata <= {30'h0, rate_q};
         end else if (s_araddr[3:2] == pmc_pkg::STATUS_OFF[3:2]) begin
            s_rdata <= {12'h0, core_mult, pwr, 1'b0, state_q};
         end
      end else if (s_rvalid && s_rready) begin
         s_rvalid  <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // ****************************************************
   // Mode sequencer
   // ****************************************************
   // Hibernate and wake events outrank software requests
   always_comb begin
      go_d  = 1'b0;
      tgt_d = tgt_q;
      case (state_q)
         pmc_pkg::ST_FULL, pmc_pkg::ST_ACT: begin
            if (hib_wr) begin
               go_d  = 1'b1;
               tgt_d = pmc_pkg::ST_HIB;
            end else if (mode_wr && cmd >= pmc_pkg::CMD_FULL
                         && cmd <= pmc_pkg::CMD_DEEP
                         && cmd_state(cmd) != state_q) begin
               // A disabled PLL blocks full-on and sleep
               if (!(pll_dis_q && cmd != pmc_pkg::CMD_DEEP)) begin
                  go_d  = 1'b1;
                  tgt_d = cmd_state(cmd);
               end
            end
         end
         pmc_pkg::ST_SLEEP: begin
            if (wake_event || rtc_irq || can_wake) begin
               go_d  = 1'b1;
               tgt_d = bypass_q ? pmc_pkg::ST_ACT : pmc_pkg::ST_FULL;
            end
         end
         pmc_pkg::ST_DEEP: begin
            if (reset_wake) begin
               go_d  = 1'b1;
               tgt_d = pmc_pkg::ST_FULL;
            end else if (rtc_irq || can_wake) begin
               go_d  = 1'b1;
               tgt_d = pmc_pkg::ST_ACT;
            end
         end
         pmc_pkg::ST_HIB: begin
            if (rtc_irq || can_wake || reset_wake || ext_wake) begin
               go_d  = 1'b1;
               tgt_d = pmc_pkg::ST_FULL;
            end
         end
         default: begin
            go_d = 1'b0;
         end
      endcase
   end

   // Settle window hides the new mode until clocks are stable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pmc_pkg::ST_FULL;
         tgt_q   <= pmc_pkg::ST_FULL;
         cnt_q   <= 4'h0;
      end else if (go_d) begin
         state_q <= pmc_pkg::ST_SET;
         tgt_q   <= tgt_d;
         cnt_q   <= pmc_pkg::SETTLE_CYC;
      end else if (state_q == pmc_pkg::ST_SET) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h1) begin
            state_q <= tgt_q;
         end
      end
   end

   // Clock and power outputs follow the mode being entered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr       <= 7'b1011110;
         core_mult <= pmc_pkg::MULT_RST;
      end else begin
         pwr <= settings(go_d ? tgt_d : tgt_q, pll_dis_q);
         if (go_d && tgt_d == pmc_pkg::ST_FULL) begin
            core_mult <= mult_pend_q;
         end
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_full_on_pll: assert property (
      state_q == pmc_pkg::ST_FULL |-> pwr.pll_en && !pwr.pll_bypass
         && pwr.core_clk_en)
      else $error("full-on clocks wrong");
   chk_active_bypass: assert property (
      state_q == pmc_pkg::ST_ACT |-> pwr.pll_bypass && pwr.core_clk_en
         && pwr.sys_clk_en && pwr.dma_l1_ok)
      else $error("active clocks wrong");
   chk_mult_hold: assert property (
      go_d && tgt_d != pmc_pkg::ST_FULL |=> $stable(core_mult))
      else $error("multiplier changed outside full-on");
   chk_sleep_clocks: assert property (
      state_q == pmc_pkg::ST_SLEEP |-> !pwr.core_clk_en
         && pwr.sys_clk_en && pwr.pll_en && !pwr.dma_l1_ok)
      else $error("sleep clocks wrong");
   chk_sleep_wake: assert property (
      state_q == pmc_pkg::ST_SLEEP && wake_event && !bypass_q
      |=> tgt_q == pmc_pkg::ST_FULL ##10 state_q == pmc_pkg::ST_FULL)
      else $error("sleep wake target wrong");
   chk_deep_off: assert property (
      state_q == pmc_pkg::ST_DEEP |-> !pwr.pll_en && !pwr.sys_clk_en
         && pwr.async_block)
      else $error("deep sleep clocks wrong");
   chk_deep_ignore: assert property (
      state_q == pmc_pkg::ST_DEEP && !rtc_irq && !can_wake
         && !reset_wake |=> state_q == pmc_pkg::ST_DEEP)
      else $error("deep sleep left without cause");
   chk_deep_rtc: assert property (
      state_q == pmc_pkg::ST_DEEP && rtc_irq && !reset_wake
      |=> state_q == pmc_pkg::ST_SET ##10 state_q == pmc_pkg::ST_ACT)
      else $error("rtc did not give active");
   chk_deep_reset: assert property (
      state_q == pmc_pkg::ST_DEEP && reset_wake
      |-> ##11 state_q == pmc_pkg::ST_FULL)
      else $error("reset did not give full-on");
   chk_hib_power: assert property (
      hib_wr && state_q == pmc_pkg::ST_ACT
      |=> !pwr.core_power && rate_q == pmc_pkg::RATE_OFF)
      else $error("hibernate not entered");
   // Cycles spent settling; a counter keeps the check cheap to unroll
   logic [3:0] set_run_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         set_run_q <= 4'h0;
      end else if (state_q == pmc_pkg::ST_SET) begin
         set_run_q <= set_run_q + 4'h1;
      end else begin
         set_run_q <= 4'h0;
      end
   end
   chk_settle_hold: assert property (
      $fell(state_q == pmc_pkg::ST_SET)
      |-> set_run_q == pmc_pkg::SETTLE_CYC)
      else $error("mode reported before settle");

   cov_sleep_to_act: cover property (
      state_q == pmc_pkg::ST_SLEEP ##1 tgt_q == pmc_pkg::ST_ACT);
   cov_hib_wake: cover property (
      state_q == pmc_pkg::ST_HIB && can_wake);
   cov_deep_rtc: cover property (
      state_q == pmc_pkg::ST_DEEP && rtc_irq);

endmodule
`default_nettype wire

// [verif/power_mode_controller_tb.sv]
// Self-checking testbench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module power_mode_controller_tb;

   // ****************************************************
   // Stimulus signals and model state
   // ****************************************************
   logic               clk       = 1'b0;
   logic               rst_n     = 1'b0;
   logic [3:0]         s_awaddr  = 4'h0;
   logic               s_awvalid = 1'b0;
   logic               s_awready;
   logic [31:0]        s_wdata   = 32'h0;
   logic               s_wvalid  = 1'b0;
   logic               s_wready;
   logic [1:0]         s_bresp;
   logic               s_bvalid;
   logic [3:0]         s_araddr  = 4'h0;
   logic               s_arvalid = 1'b0;
   logic               s_arready;
   logic [31:0]        s_rdata;
   logic [1:0]         s_rresp;
   logic               s_rvalid;
   logic [4:0]         wk        = 5'h0;
   pmc_pkg::pmc_pwr_t  pwr;
   logic [5:0]         core_mult;
   logic [31:0]        r;
   logic [5:0]         mq;
   logic [5:0]         app;
   logic               dis;
   int                 num_errors;
   int                 samples_checked;

   // 125 MHz clock
   always #4 clk = ~clk;

   // Ready for responses is held high all run, which the bus allows
   pmc_top pmc_top_i (
      .clk       (clk),
      .rst_n     (rst_n),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (4'hF),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (1'b1),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (1'b1),
      .wake_event(wk[0]),
      .rtc_irq   (wk[1]),
      .can_wake  (wk[2]),
      .ext_wake  (wk[3]),
      .reset_wake(wk[4]),
      .pwr       (pwr),
      .core_mult (core_mult)
   );

   // ****************************************************
   // Checking and closing
   // ****************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ****************************************************
   // Bus tasks
   // ****************************************************
   // Address and data are offered together and released as each is taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) break;
      end
      check(s_bresp, pmc_pkg::RESP_OKAY);
   endtask

   // Waits for the answer however long it takes; the watchdog ends a hang
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) break;
      end
      d = s_rdata;
      check(s_rresp, pmc_pkg::RESP_OKAY);
   endtask

   // ****************************************************
   // Model of the mode table
   // ****************************************************
   // Returns {mask, value}; fields the table leaves open are masked out
   function automatic logic [13:0] pexp(input logic [5:0] st);
      case (st)
         6'h01:   return {7'h7E, 7'h5E};
         6'h02:   return {7'h7E, dis ? 7'h3E : 7'h7E};
         6'h04:   return {7'h5E, 7'h4C};
         6'h08:   return {7'h5D, 7'h05};
         default: return {7'h5C, 7'h00};
      endcase
   endfunction

   task automatic req(input logic [2:0] c);
      axi_wr(pmc_pkg::MODE_REQ_OFF, {29'h0, c});
   endtask

   task automatic pll_wr(input logic [5:0] m, input logic b, input logic d);
      axi_wr(pmc_pkg::PLL_CONTROL_REG_OFF, {22'h0, m, 2'h0, b, d});
   endtask

   // One wake input high for a single cycle, then a quiet edge
   task automatic pulse(input int k);
      wk <= 5'(1 << k);
      @(posedge clk);
      wk <= 5'h0;
      @(posedge clk);
   endtask

   // Settling is seen first when a move is due, then the target mode
   task automatic expect_mode(input logic [5:0] st, input bit moved);
      logic [13:0] m;
      int          n;
      n = 0;
      axi_rd(pmc_pkg::STATUS_OFF, r);
      if (moved) check(r[5:0], 6'h20);
      while (r[5:0] === 6'h20 && n < 30) begin
         axi_rd(pmc_pkg::STATUS_OFF, r);
         n++;
      end
      m = pexp(st);
      if (st == 6'h01) app = mq;
      check(r[5:0], st);
      check(7'(pwr) & m[13:7], m[6:0]);
      check(r[13:7], 7'(pwr));
      check(core_mult, app);
      check(r[19:14], app);
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      void'($urandom(32'h012F));
      num_errors = 0;
      samples_checked = 0;
      mq = pmc_pkg::MULT_RST;
      app = pmc_pkg::MULT_RST;
      dis = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      expect_mode(6'h01, 0);
      axi_rd(pmc_pkg::MODE_REQ_OFF, r);
      check(r, 32'h0);
      req(pmc_pkg::CMD_ACT);
      expect_mode(6'h02, 1);
      // New multiplier held back while bypassed; PLL switched off
      mq = 6'h0B + 6'($urandom % 40);
      pll_wr(mq, 1'b1, 1'b1);
      dis = 1'b1;
      axi_rd(pmc_pkg::PLL_CONTROL_REG_OFF, r);
      check(r[9:0], {mq, 4'h3});
      expect_mode(6'h02, 0);
      req(pmc_pkg::CMD_FULL);
      expect_mode(6'h02, 0);
      req(pmc_pkg::CMD_SLEEP);
      expect_mode(6'h02, 0);
      pll_wr(mq, 1'b1, 1'b0);
      dis = 1'b0;
      req(pmc_pkg::CMD_SLEEP);
      expect_mode(6'h04, 1);
      pulse(3);
      pulse(4);
      expect_mode(6'h04, 0);
      pulse(0);
      expect_mode(6'h02, 1);
      pll_wr(mq, 1'b0, 1'b0);
      req(pmc_pkg::CMD_SLEEP);
      expect_mode(6'h04, 1);
      pulse(0);
      expect_mode(6'h01, 1);
      req(pmc_pkg::CMD_DEEP);
      expect_mode(6'h08, 1);
      pulse(0);
      pulse(3);
      expect_mode(6'h08, 0);
      pulse(1);
      expect_mode(6'h02, 1);
      req(pmc_pkg::CMD_FULL);
      expect_mode(6'h01, 1);
      req(pmc_pkg::CMD_DEEP);
      expect_mode(6'h08, 1);
      pulse(4);
      expect_mode(6'h01, 1);
      req(pmc_pkg::CMD_DEEP);
      expect_mode(6'h08, 1);
      pulse(2);
      expect_mode(6'h02, 1);
      req(pmc_pkg::CMD_SLEEP);
      expect_mode(6'h04, 1);
      pulse(2);
      expect_mode(6'h01, 1);
      // Restore the default multiplier so a core power loss cannot matter
      mq = pmc_pkg::MULT_RST;
      pll_wr(mq, 1'b0, 1'b0);
      for (int k = 1; k < 5; k++) begin
         // Odd passes enter hibernate from active rather than full-on
         if (k % 2 == 1) begin
            req(pmc_pkg::CMD_ACT);
            expect_mode(6'h02, 1);
         end
         axi_wr(pmc_pkg::REG_CTL_OFF, {30'h0, pmc_pkg::RATE_OFF});
         expect_mode(6'h10, 1);
         pulse(k);
         expect_mode(6'h01, 1);
         axi_rd(pmc_pkg::REG_CTL_OFF, r);
         check(r[1:0], pmc_pkg::RATE_RST);
      end
      conclude();
   end

   // Whole run is well under a thousand cycles; stop long after that
   initial begin
      #(8 * 20000);
      num_errors++;
      conclude();
   end

endmodule
`default_nettype wire
